// *** src/acp_host.sv ***
/*
  Host end of the amplifier configuration port. Software drives it through a
  small register port; it makes the serial clock by a divider, sends words
  msb first and can keep select low across words for a chain.
  Assumes the device samples on clock rise and the data-out pin is synced here.
*/
`timescale 1ns/100ps
`default_nettype none
module acp_host (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  acp_if.host LINK,
  input wire logic [3:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O
);
  localparam int W = acp_pkg::WORD_W;
  localparam int CW = acp_pkg::CNT_W;
  localparam logic [CW-1:0] HALF = CW'(acp_pkg::SCK_HALF_CYC - 1);
  localparam logic [CW-1:0] GUARD = CW'(acp_pkg::CS_GUARD_CYC - 1);

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} acp_hst_t;

  logic sdo_meta_r;
  logic sdo_s_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      sdo_meta_r <= 1'b1;
      sdo_s_r <= 1'b1;
    end else begin
      sdo_meta_r <= LINK.serial_out_pin;
      sdo_s_r <= sdo_meta_r;
    end
  end

  acp_hst_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [W-1:0] txw_r, txw_nxt;
  logic [W-1:0] tx_r, tx_nxt;
  logic [W-1:0] rx_r, rx_nxt;
  logic [3:0] par_r, par_nxt;
  logic par_mode_r, par_mode_nxt;
  logic last_r, last_nxt;
  logic open_r, open_nxt;
  logic cs_r, cs_nxt;
  logic sck_r, sck_nxt;
  logic sdi_r, sdi_nxt;
  logic [15:0] rdata_nxt;
  logic busy;
  logic tick;

  always_comb begin
    busy = (st_r != H_IDLE);
    tick = (cnt_r == '0);
    st_nxt = st_r;
    cnt_nxt = tick ? cnt_r : cnt_r - 1'b1;
    bits_nxt = bits_r;
    txw_nxt = txw_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    par_nxt = par_r;
    par_mode_nxt = par_mode_r;
    last_nxt = last_r;
    open_nxt = open_r;
    cs_nxt = cs_r;
    sck_nxt = sck_r;
    sdi_nxt = sdi_r;
    rdata_nxt = 16'h0000;
    if (RD_I) begin
      if (ADDR_I == acp_pkg::REG_TX) begin
        rdata_nxt = txw_r;
      end else if (ADDR_I == acp_pkg::REG_CTRL) begin
        rdata_nxt = {13'h0000, par_mode_r, last_r, 1'b0};
      end else if (ADDR_I == acp_pkg::REG_PAR) begin
        rdata_nxt = {12'h000, par_r};
      end else if (ADDR_I == acp_pkg::REG_STAT) begin
        rdata_nxt = {13'h0000, par_mode_r, open_r, busy};
      end else if (ADDR_I == acp_pkg::REG_RX) begin
        rdata_nxt = rx_r;
      end
    end
    if (WR_I) begin
      if (ADDR_I == acp_pkg::REG_TX) begin
        txw_nxt = WDATA_I;
      end else if (ADDR_I == acp_pkg::REG_PAR) begin
        par_nxt = WDATA_I[3:0];
      end
    end
    case (st_r)
      H_IDLE: begin
        if (WR_I && ADDR_I == acp_pkg::REG_CTRL) begin
          last_nxt = WDATA_I[acp_pkg::CTRL_LAST];
          if (!open_r) begin
            par_mode_nxt = WDATA_I[acp_pkg::CTRL_PAR];
          end
          if (WDATA_I[acp_pkg::CTRL_GO] && !(open_r ? par_mode_r : WDATA_I[acp_pkg::CTRL_PAR])) begin
            tx_nxt = txw_r;
            bits_nxt = 5'd0;
            sck_nxt = 1'b1;
            cs_nxt = 1'b0;
            cnt_nxt = open_r ? '0 : GUARD;
            st_nxt = open_r ? H_LOW : H_LEAD;
          end
        end
      end
      H_LEAD: begin
        if (tick) begin
          st_nxt = H_LOW;
        end
      end
      H_LOW: begin
        if (tick) begin
          sck_nxt = 1'b0;
          sdi_nxt = tx_r[W-1];
          cnt_nxt = HALF;
          st_nxt = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          sck_nxt = 1'b1;
          rx_nxt = {rx_r[W-2:0], sdo_s_r};
          tx_nxt = {tx_r[W-2:0], 1'b0};
          bits_nxt = bits_r + 5'd1;
          cnt_nxt = HALF;
          if (bits_r == 5'(W - 1)) begin
            if (last_r) begin
              st_nxt = H_TAIL;
            end else begin
              open_nxt = 1'b1;
              st_nxt = H_TAIL;
            end
          end else begin
            st_nxt = H_LOW;
          end
        end
      end
      H_TAIL: begin
        // Clock stays high for the whole high half before select rises
        if (tick) begin
          if (last_r) begin
            cs_nxt = 1'b1;
            open_nxt = 1'b0;
            cnt_nxt = GUARD;
            st_nxt = H_GAP;
          end else begin
            st_nxt = H_IDLE;
          end
        end
      end
      default: begin
        if (tick) begin
          st_nxt = H_IDLE;
        end
      end
    endcase
    if (par_mode_nxt && st_nxt == H_IDLE) begin
      cs_nxt = par_nxt[acp_pkg::PAR_POWER_DOWN_REQUEST];
      sck_nxt = par_nxt[2];
      sdi_nxt = par_nxt[1];
    end else if (par_mode_r && !par_mode_nxt) begin
      cs_nxt = 1'b1;
      sck_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      st_r <= H_IDLE;
      cnt_r <= '0;
      bits_r <= 5'd0;
      txw_r <= acp_pkg::WORD_RESET;
      tx_r <= acp_pkg::WORD_RESET;
      rx_r <= acp_pkg::WORD_RESET;
      par_r <= 4'h0;
      par_mode_r <= 1'b0;
      last_r <= 1'b1;
      open_r <= 1'b0;
      cs_r <= 1'b1;
      sck_r <= 1'b1;
      sdi_r <= 1'b0;
      RDATA_O <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bits_r <= bits_nxt;
      txw_r <= txw_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      par_r <= par_nxt;
      par_mode_r <= par_mode_nxt;
      last_r <= last_nxt;
      open_r <= open_nxt;
      cs_r <= cs_nxt;
      sck_r <= sck_nxt;
      sdi_r <= sdi_nxt;
      RDATA_O <= rdata_nxt;
    end
  end

  assign LINK.chip_select_n = cs_r;
  assign LINK.serial_clock = sck_r;
  assign LINK.serial_in = sdi_r;
  assign LINK.host_g0 = par_r[0];
  assign LINK.host_g0_oe = par_mode_r;
  assign LINK.mode_level_pin_a = par_mode_r ? acp_pkg::LVL_HIGH : acp_pkg::LVL_LOW;
  assign LINK.mode_level_pin_b = par_mode_r ? acp_pkg::LVL_LOW : acp_pkg::LVL_HIGH;
endmodule
`default_nettype wire

// *** src/acp_pkg.sv ***
/*
  Shared constants for the amplifier configuration serial port: control word
  layout, reset value, link timing, host register map and gain decoding.
  Assumes a 100 MHz system clock on both ends.
*/
package acp_pkg;
  localparam int WORD_W = 16;
  localparam int LVL_W = 8;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // Control word fields
  localparam int F_GAIN = 0;
  localparam int F_COMP = 3;
  localparam int F_ROUTE = 6;
  localparam int F_SIGN = 8;
  localparam int F_PDOWN = 9;
  localparam int F_EXT_CAP_FILTER_ENABLE = 10;
  localparam int F_FPIN = 11;
  localparam int F_FLEVEL = 12;
  localparam int F_SPARE = 15;

  localparam logic [2:0] GAIN_EXT = 3'h7;
  localparam logic [2:0] COMP_L0 = 3'h0;
  localparam logic [2:0] COMP_L1 = 3'h1;
  localparam logic [2:0] COMP_L2 = 3'h2;
  localparam logic [2:0] COMP_L3 = 3'h3;
  localparam logic [2:0] COMP_L4 = 3'h4;

  // Logic levels the host puts on the two mode level pins
  localparam logic [LVL_W-1:0] LVL_LOW = 8'h00;
  localparam logic [LVL_W-1:0] LVL_HIGH = 8'hff;

  // Link timing
  localparam int CLK_NS = 10;
  localparam int SCK_HALF_NS = 100;
  localparam int CS_GUARD_NS = 50;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GUARD_CYC = (CS_GUARD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  // Host command registers
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_TX = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PAR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_RX = 4'h4;
  localparam int CTRL_GO = 0;
  localparam int CTRL_LAST = 1;
  localparam int CTRL_PAR = 2;
  localparam int PAR_POWER_DOWN_REQUEST = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OPEN = 1;
  localparam int STAT_PAR = 2;

  // Compensation picked automatically from the gain code in parallel mode
  function automatic logic [2:0] par_comp(input logic [2:0] g);
    logic [2:0] c;
    c = COMP_L4;
    case (g)
      3'h0, 3'h1: c = COMP_L0;
      3'h2: c = COMP_L1;
      3'h3, 3'h4: c = COMP_L2;
      3'h5, 3'h6: c = COMP_L3;
      default: c = COMP_L4;
    endcase
    return c;
  endfunction

  // Gain multiplier; zero means set by external resistors
  function automatic logic [9:0] gain_mult(input logic [2:0] g);
    logic [9:0] m;
    m = 10'd0;
    case (g)
      3'h0: m = 10'd10;
      3'h1: m = 10'd20;
      3'h2: m = 10'd50;
      3'h3: m = 10'd100;
      3'h4: m = 10'd200;
      3'h5: m = 10'd500;
      3'h6: m = 10'd1000;
      default: m = 10'd0;
    endcase
    return m;
  endfunction
endpackage

// *** src/acp_if.sv ***
/*
  Pins between the configuration host and the amplifier's configuration port.
  The shared data-out pin is resolved here from the two enables; undriven it
  floats high.
*/
`timescale 1ns/100ps
`default_nettype none
interface acp_if;
  logic [acp_pkg::LVL_W-1:0] mode_level_pin_a;
  logic [acp_pkg::LVL_W-1:0] mode_level_pin_b;
  logic chip_select_n;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic host_g0;
  logic host_g0_oe;
  logic serial_out_pin;

  assign serial_out_pin = serial_out_oe ? serial_out : (host_g0_oe ? host_g0 : 1'b1);

  modport dev (
    input mode_level_pin_a, mode_level_pin_b, chip_select_n, serial_clock,
    input serial_in, serial_out_pin,
    output serial_out, serial_out_oe
  );
  modport host (
    output mode_level_pin_a, mode_level_pin_b, chip_select_n, serial_clock,
    output serial_in, host_g0, host_g0_oe,
    input serial_out_pin
  );
endinterface
`default_nettype wire

// *** src/acp_device.sv ***
/*
  Device end of the amplifier configuration port: mode selection, serial
  shift and holding register, daisy-chain output and parallel pin decode.
  Assumes link pins come from another domain; all are synchronised here.
  RESET_I stands for power-on reset.
*/
// Notes on behaviour
// - Serial when level pin a below pin b
// - Parallel: pins set gain and shutdown
// - Fault features only reachable in serial mode
// - Parallel gain code picks fixed compensation
// - Sixteen-bit control word, written only serially
// - Fixed field layout of the control word
// - Shift register feeds separate holding register
// - Host sends sixteen bits, top bit zero
// - Chip select fall arms the shift register
// - Host keeps clock high at select edges
// - Data sampled on clock rise, select low
// - Select rise copies shift into holding
// - Shifted-out bits appear on serial out
// - Host writes word right after power-on
// - Power-on word is all zeros
// - Shared select writes same word everywhere
// - Serial out chains into next serial in
// - Host sends farthest device's word first
// - Gain codes map to fixed or external gain
// - Compensation top bit set means level four
`timescale 1ns/100ps
`default_nettype none
module acp_device (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  acp_if.dev LINK,
  output logic SERIAL_MODE_O,
  output logic [2:0] GAIN_CODE_O,
  output logic [9:0] GAIN_MULT_O,
  output logic GAIN_EXT_O,
  output logic [2:0] COMP_LEVEL_O,
  output logic [2:0] COMP_STEP_O,
  output logic [1:0] ROUTE_SELECT_O,
  output logic SIGN_INVERT_O,
  output logic POWER_DOWN_O,
  output logic FILTER_ENABLE_O,
  output logic FAULT_AVAIL_O,
  output logic FAULT_PIN_SELECT_O,
  output logic [2:0] FAULT_TEST_LEVEL_O,
  output logic [15:0] HOLD_WORD_O
);
  localparam int W = acp_pkg::WORD_W;
  localparam int LW = acp_pkg::LVL_W;
  localparam int NS = 4 + 2 * LW;
  // Idle link reads select and clock high
  localparam logic [NS-1:0] SYNC_RST = {{(2 * LW){1'b0}}, 4'hc};

  logic [NS-1:0] pins;
  logic [NS-1:0] meta_r;
  logic [NS-1:0] sync_r;
  logic cs_s;
  logic sck_s;
  logic sdi_s;
  logic g0_s;
  logic [LW-1:0] lvl_a_s;
  logic [LW-1:0] lvl_b_s;

  assign pins = {LINK.mode_level_pin_a, LINK.mode_level_pin_b, LINK.chip_select_n,
                 LINK.serial_clock, LINK.serial_in, LINK.serial_out_pin};

  // Level pins are quasi-static straps, so a plain vector sync is enough
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      meta_r <= SYNC_RST;
      sync_r <= SYNC_RST;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  assign lvl_a_s = sync_r[NS-1 -: LW];
  assign lvl_b_s = sync_r[NS-1-LW -: LW];
  assign cs_s = sync_r[3];
  assign sck_s = sync_r[2];
  assign sdi_s = sync_r[1];
  assign g0_s = sync_r[0];

  // Link state
  logic cs_d_r, cs_d_nxt;
  logic sck_d_r, sck_d_nxt;
  logic serial_r, serial_nxt;
  logic armed_r, armed_nxt;
  logic [W-1:0] shift_r, shift_nxt;
  logic [W-1:0] hold_r, hold_nxt;
  logic sdo_r, sdo_nxt;
  logic sdo_oe_r, sdo_oe_nxt;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;

  always_comb begin
    cs_fall = cs_d_r & ~cs_s;
    cs_rise = ~cs_d_r & cs_s;
    sck_rise = ~sck_d_r & sck_s;
    cs_d_nxt = cs_s;
    sck_d_nxt = sck_s;
    serial_nxt = serial_r;
    armed_nxt = armed_r;
    shift_nxt = shift_r;
    hold_nxt = hold_r;
    // Equal levels are not a valid strap; the last mode is kept
    if (lvl_a_s < lvl_b_s) begin
      serial_nxt = 1'b1;
    end else if (lvl_a_s > lvl_b_s) begin
      serial_nxt = 1'b0;
    end
    if (!serial_nxt) begin
      armed_nxt = 1'b0;
    end else if (cs_fall) begin
      armed_nxt = 1'b1;
    end else if (cs_rise) begin
      armed_nxt = 1'b0;
    end
    // Clock edges outside an armed frame are dropped
    if (armed_r && !cs_s && sck_rise) begin
      shift_nxt = {shift_r[W-2:0], sdi_s};
    end
    // The word is only committed whole, so settings never pass through
    // a half-shifted value
    if (armed_r && serial_r && cs_rise) begin
      hold_nxt = shift_r;
    end
    // Data out changes a few cycles after the clock rise, so the next device
    // in a chain still samples the previous bit on that same rise
    sdo_nxt = shift_nxt[W-1];
    sdo_oe_nxt = serial_nxt & ~cs_s;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b1;
      serial_r <= 1'b1;
      armed_r <= 1'b0;
      shift_r <= acp_pkg::WORD_RESET;
      hold_r <= acp_pkg::WORD_RESET;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else begin
      cs_d_r <= cs_d_nxt;
      sck_d_r <= sck_d_nxt;
      serial_r <= serial_nxt;
      armed_r <= armed_nxt;
      shift_r <= shift_nxt;
      hold_r <= hold_nxt;
      sdo_r <= sdo_nxt;
      sdo_oe_r <= sdo_oe_nxt;
    end
  end

  assign LINK.serial_out = sdo_r;
  assign LINK.serial_out_oe = sdo_oe_r;

  // Effective settings
  logic [2:0] gain_nxt;
  logic [2:0] comp_nxt;
  logic [2:0] step_nxt;
  logic [1:0] route_nxt;
  logic sign_nxt;
  logic pdown_nxt;
  logic ext_cap_filter_enable_nxt;
  logic fpin_nxt;
  logic [2:0] flevel_nxt;

  always_comb begin
    if (serial_r) begin
      gain_nxt = hold_r[acp_pkg::F_GAIN +: 3];
      comp_nxt = hold_r[acp_pkg::F_COMP +: 3];
      route_nxt = hold_r[acp_pkg::F_ROUTE +: 2];
      sign_nxt = hold_r[acp_pkg::F_SIGN];
      pdown_nxt = hold_r[acp_pkg::F_PDOWN];
      ext_cap_filter_enable_nxt = hold_r[acp_pkg::F_EXT_CAP_FILTER_ENABLE];
      fpin_nxt = hold_r[acp_pkg::F_FPIN];
      flevel_nxt = hold_r[acp_pkg::F_FLEVEL +: 3];
    end else begin
      // Pins are shared: clock is gain msb, data in the middle bit,
      // data out the lsb, select is shutdown
      gain_nxt = {sck_s, sdi_s, g0_s};
      comp_nxt = acp_pkg::par_comp(gain_nxt);
      route_nxt = 2'h0;
      sign_nxt = 1'b0;
      pdown_nxt = cs_s;
      ext_cap_filter_enable_nxt = 1'b0;
      fpin_nxt = 1'b0;
      flevel_nxt = 3'h0;
    end
    if (comp_nxt[2]) begin
      step_nxt = acp_pkg::COMP_L4;
    end else begin
      step_nxt = comp_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      SERIAL_MODE_O <= 1'b1;
      GAIN_CODE_O <= 3'h0;
      GAIN_MULT_O <= 10'd10;
      GAIN_EXT_O <= 1'b0;
      COMP_LEVEL_O <= 3'h0;
      COMP_STEP_O <= 3'h0;
      ROUTE_SELECT_O <= 2'h0;
      SIGN_INVERT_O <= 1'b0;
      POWER_DOWN_O <= 1'b0;
      FILTER_ENABLE_O <= 1'b0;
      FAULT_AVAIL_O <= 1'b1;
      FAULT_PIN_SELECT_O <= 1'b0;
      FAULT_TEST_LEVEL_O <= 3'h0;
      HOLD_WORD_O <= acp_pkg::WORD_RESET;
    end else begin
      SERIAL_MODE_O <= serial_r;
      GAIN_CODE_O <= gain_nxt;
      GAIN_MULT_O <= acp_pkg::gain_mult(gain_nxt);
      GAIN_EXT_O <= (gain_nxt == acp_pkg::GAIN_EXT);
      COMP_LEVEL_O <= comp_nxt;
      COMP_STEP_O <= step_nxt;
      ROUTE_SELECT_O <= route_nxt;
      SIGN_INVERT_O <= sign_nxt;
      POWER_DOWN_O <= pdown_nxt;
      FILTER_ENABLE_O <= ext_cap_filter_enable_nxt;
      FAULT_AVAIL_O <= serial_r;
      FAULT_PIN_SELECT_O <= fpin_nxt;
      FAULT_TEST_LEVEL_O <= flevel_nxt;
      HOLD_WORD_O <= hold_r;
    end
  end
endmodule
`default_nettype wire

// *** verif/acp_assertions.sv ***
/*
  Checker for the configuration link between host and device ends.
  Assumes one 100 MHz clock, synchronous high reset, and the device's mode
  and holding-word outputs wired in beside the link pins.
*/
`timescale 1ns/100ps
`default_nettype none
module acp_assertions (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [acp_pkg::LVL_W-1:0] mode_level_pin_a,
  input wire logic [acp_pkg::LVL_W-1:0] mode_level_pin_b,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out_oe,
  input wire logic SERIAL_MODE_O,
  input wire logic [15:0] HOLD_WORD_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  wire logic ser_lvl;
  assign ser_lvl = mode_level_pin_a < mode_level_pin_b;

  AST_MODE_SERIAL: assert property (ser_lvl [*8] |-> SERIAL_MODE_O)
    else $error("serial levels but not serial mode");
  AST_MODE_PARALLEL: assert property ((!ser_lvl) [*8] |-> !SERIAL_MODE_O && !serial_out_oe)
    else $error("parallel levels but serial behaviour");
  AST_CS_FALL_SCK_HIGH: assert property ($fell(chip_select_n) && ser_lvl |-> serial_clock [*4])
    else $error("clock not high around select fall");
  AST_CS_RISE_SCK_HIGH: assert property ($rose(chip_select_n) && ser_lvl |-> serial_clock ##1 serial_clock)
    else $error("clock not high at select rise");
  AST_SDI_STABLE: assert property ($rose(serial_clock) && !chip_select_n && ser_lvl |-> $stable(serial_in))
    else $error("data moved at clock rise");
  AST_OE_RELEASED: assert property (chip_select_n [*8] |-> !serial_out_oe)
    else $error("data out driven while deselected");
  AST_HOLD_RESET: assert property ($fell(RESET_I) |-> HOLD_WORD_O == 16'h0000)
    else $error("holding word not zero after reset");
  AST_HOLD_ON_COMMIT: assert property ($changed(HOLD_WORD_O) |-> chip_select_n && $past(chip_select_n, 3))
    else $error("holding word changed outside commit");
  AST_HOLD_STEADY: assert property (chip_select_n [*8] ##1 chip_select_n [*4] |=> $stable(HOLD_WORD_O))
    else $error("holding word moved while deselected");

  cover property ($rose(chip_select_n) && ser_lvl);
  cover property ($changed(HOLD_WORD_O));
  cover property ((!ser_lvl) [*8]);
endmodule
`default_nettype wire

// *** verif/test_amp_config_serial_port.sv ***
/*
  Bench: host and device joined by one link, plus a second device driven
  bit by bit by the bench to break the host's rules on purpose.
  Assumes 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module test_amp_config_serial_port;
  logic clk;
  logic rst;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic ser;
  logic [2:0] gcode;
  logic [9:0] gmult;
  logic gext;
  logic [2:0] clev;
  logic [2:0] cstep;
  logic [1:0] route;
  logic sinv;
  logic pdown;
  logic ext_cap_filter_enable;
  logic favail;
  logic fpin;
  logic [2:0] flev;
  logic [15:0] hold;
  logic [15:0] hold_b;
  logic [15:0] d;
  int fail_count;
  int num_checks;
  logic [9:0] mult_tab [8] = '{10'h00a, 10'h014, 10'h032, 10'h064, 10'h0c8, 10'h1f4, 10'h3e8, 10'h000};
  logic [2:0] comp_tab [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};

  acp_if link();
  acp_if link_b();
  acp_host i_acp_host(.CLK_SYS_I(clk), .RESET_I(rst), .LINK(link.host), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  acp_device i_acp_device(.CLK_SYS_I(clk), .RESET_I(rst), .LINK(link.dev),
    .SERIAL_MODE_O(ser), .GAIN_CODE_O(gcode), .GAIN_MULT_O(gmult), .GAIN_EXT_O(gext),
    .COMP_LEVEL_O(clev), .COMP_STEP_O(cstep), .ROUTE_SELECT_O(route), .SIGN_INVERT_O(sinv),
    .POWER_DOWN_O(pdown), .FILTER_ENABLE_O(ext_cap_filter_enable), .FAULT_AVAIL_O(favail),
    .FAULT_PIN_SELECT_O(fpin), .FAULT_TEST_LEVEL_O(flev), .HOLD_WORD_O(hold));
  acp_device i_acp_device_b(.CLK_SYS_I(clk), .RESET_I(rst), .LINK(link_b.dev),
    .SERIAL_MODE_O(), .GAIN_CODE_O(), .GAIN_MULT_O(), .GAIN_EXT_O(), .COMP_LEVEL_O(),
    .COMP_STEP_O(), .ROUTE_SELECT_O(), .SIGN_INVERT_O(), .POWER_DOWN_O(),
    .FILTER_ENABLE_O(), .FAULT_AVAIL_O(), .FAULT_PIN_SELECT_O(), .FAULT_TEST_LEVEL_O(),
    .HOLD_WORD_O(hold_b));
  acp_assertions i_acp_assertions(.CLK_SYS_I(clk), .RESET_I(rst),
    .mode_level_pin_a(link.mode_level_pin_a), .mode_level_pin_b(link.mode_level_pin_b),
    .chip_select_n(link.chip_select_n), .serial_clock(link.serial_clock),
    .serial_in(link.serial_in), .serial_out_oe(link.serial_out_oe),
    .SERIAL_MODE_O(ser), .HOLD_WORD_O(hold));

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Bounded poll; a host still busy when it runs out counts as a mismatch
  task automatic send(input logic [15:0] w, input logic last);
    wr_reg(acp_pkg::REG_TX, w);
    wr_reg(acp_pkg::REG_CTRL, {14'h0000, last, 1'b1});
    d = 16'h0001;
    repeat (400) if (d[0] !== 1'b0) rd_reg(acp_pkg::REG_STAT, d);
    chk("done", {15'h0000, d[0]}, 16'h0000);
    repeat (10) @(posedge clk);
  endtask

  task automatic chk_word(input logic [15:0] w);
    chk("hold", hold, w);
    chk("gain", gcode, w[2:0]);
    chk("mult", gmult, mult_tab[w[2:0]]);
    chk("ext", {15'h0000, gext}, {15'h0000, w[2:0] == 3'h7});
    chk("comp", clev, w[5:3]);
    chk("step", cstep, w[5] ? 3'h4 : w[5:3]);
    chk("route", route, w[7:6]);
    chk("fields", {flev, fpin, ext_cap_filter_enable, pdown, sinv}, w[14:8]);
    chk("fault", favail, 1'h1);
  endtask

  // Far-side clock runs only inside the frame, high at both select edges
  task automatic bang(input logic [19:0] v);
    link_b.chip_select_n <= 1'b0;
    #80;
    for (int i = 19; i >= 0; i--) begin
      link_b.serial_clock <= 1'b0;
      link_b.serial_in <= v[i];
      #80;
      link_b.serial_clock <= 1'b1;
      #80;
    end
    link_b.chip_select_n <= 1'b1;
    link_b.serial_in <= ~v[0];
    #80;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rst = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    fail_count = 0;
    num_checks = 0;
    link_b.mode_level_pin_a = acp_pkg::LVL_LOW;
    link_b.mode_level_pin_b = acp_pkg::LVL_HIGH;
    link_b.chip_select_n = 1'b1;
    link_b.serial_clock = 1'b1;
    link_b.serial_in = 1'b0;
    link_b.host_g0 = 1'b0;
    link_b.host_g0_oe = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk_word(16'h0000);
    chk("mode", ser, 1'h1);
    rd_reg(4'hf, d);
    chk("unmapped", d, 16'h0000);
    $display("test reset done");
    send(16'h5a6b, 1'b1);
    chk_word(16'h5a6b);
    send(16'h2597, 1'b1);
    chk_word(16'h2597);
    $display("test serial done");
    send(16'h001e, 1'b0);
    rd_reg(acp_pkg::REG_STAT, d);
    chk("open", d[1:0], 2'h2);
    chk("held", hold, 16'h2597);
    send(16'h0001, 1'b1);
    chk("near", hold, 16'h0001);
    rd_reg(acp_pkg::REG_RX, d);
    chk("passed", d, 16'h001e);
    $display("test chain done");
    wr_reg(acp_pkg::REG_CTRL, 16'h0004);
    for (int g = 0; g < 8; g++) begin
      wr_reg(acp_pkg::REG_PAR, {12'h000, g[0], g[2:0]});
      repeat (8) @(posedge clk);
      chk("pmode", ser, 1'h0);
      chk("pgain", gcode, g[2:0]);
      chk("pmult", gmult, mult_tab[g]);
      chk("pstep", cstep, comp_tab[g]);
      chk("pext", gext, g == 7);
      chk("pdown", pdown, g[0]);
      chk("pfault", favail, 1'h0);
    end
    wr_reg(acp_pkg::REG_CTRL, 16'h0005);
    rd_reg(acp_pkg::REG_STAT, d);
    chk("pgo", d[2:0], 3'h4);
    wr_reg(acp_pkg::REG_CTRL, 16'h0000);
    repeat (8) @(posedge clk);
    chk("back", ser, 1'h1);
    chk_word(16'h0001);
    $display("test parallel done");
    @(posedge clk);
    #3;
    bang(20'habcde);
    repeat (10) @(posedge clk);
    chk("long", hold_b, 16'hbcde);
    for (int i = 0; i < 3; i++) begin
      link_b.serial_clock <= 1'b0;
      link_b.serial_in <= i[0];
      #80;
      link_b.serial_clock <= 1'b1;
      #80;
    end
    repeat (10) @(posedge clk);
    chk("quiet", hold_b, 16'hbcde);
    // An empty frame commits the shift register, which must be untouched
    link_b.chip_select_n <= 1'b0;
    #80;
    link_b.chip_select_n <= 1'b1;
    #80;
    repeat (10) @(posedge clk);
    chk("idle", hold_b, 16'hbcde);
    $display("test fault driver done");
    stop_test();
  end
endmodule
`default_nettype wire
